// ===== rfs_params.svh
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH
// ----------------------------------------------------------------------
// register map, word addresses in the mac register space
// ----------------------------------------------------------------------
`define RFS_ADDR_GOOD 16'h0043
`define RFS_ADDR_BCAST 16'h0044
`define RFS_ADDR_MCAST 16'h0045
`define RFS_ADDR_MIN 16'h0046
`define RFS_ADDR_BIN2 16'h0047
`define RFS_ADDR_BIN3 16'h0048
`define RFS_ADDR_BIN4 16'h0049
`define RFS_NUM_CNT 7
`define RFS_CNT_RESET 32'h0000_0000
`define RFS_CNT_MAX 32'hFFFF_FFFF
// ----------------------------------------------------------------------
// size bin limits in bytes
// ----------------------------------------------------------------------
`define RFS_LEN_MIN 16'h0040
`define RFS_LEN_B2_LO 16'h0041
`define RFS_LEN_B2_HI 16'h007F
`define RFS_LEN_B3_LO 16'h0080
`define RFS_LEN_B3_HI 16'h00FF
`define RFS_LEN_B4_LO 16'h0100
`define RFS_LEN_B4_HI 16'h01FF
`define RFS_BCAST_DA 48'hFFFF_FFFF_FFFF
// first transmitted address bit, low bit of the first octet
`define RFS_MCAST_BIT 40
// counter width and step
`define RFS_CNT_W 32
`define RFS_CNT_ONE 32'h0000_0001
// counter indices
`define RFS_IX_GOOD 0
`define RFS_IX_BCAST 1
`define RFS_IX_MCAST 2
`define RFS_IX_MIN 3
`define RFS_IX_BIN2 4
`define RFS_IX_BIN3 5
`define RFS_IX_BIN4 6
`endif

// ===== rfs_pkg.sv
package rfs_pkg;
  // one finished frame from the receive mac
  typedef struct packed {
    logic good;
    logic [47:0] dest_addr;
    logic [15:0] length;
  } rfs_frame_type;
  // register access from the spi register engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } rfs_req_type;
  typedef struct packed {
    logic hit;
    logic [31:0] rdata;
  } rfs_rsp_type;
endpackage

// ===== rfs_sat_counter.sv
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_sat_counter #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic inc,
  input wire logic clr,
  // value
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  localparam logic [WIDTH-1:0] MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  // a clear that meets an event restarts at one, so nothing is lost
  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = inc ? ONE : '0;
    end else if (inc && count_q != MAX) begin
      count_d = count_q + ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

  property p_sat_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    (count_q == MAX && !clr) |=> count_q == MAX;
  endproperty
  a_sat_hold: assert property (p_sat_hold)
    else $error("saturated counter moved");

  property p_clr_inc;
    @(posedge ref_clk) disable iff (sys_rst)
    (clr && inc) |=> count_q == ONE;
  endproperty
  a_clr_inc: assert property (p_clr_inc)
    else $error("event lost on clearing read");
endmodule

// ===== rfs_rx_stats.sv
`timescale 1ns/1ps
`include "rfs_params.svh"
module rfs_rx_stats (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // finished frame pulse from the receive mac
  input wire logic frame_valid,
  input rfs_pkg::rfs_frame_type frame,
  // register access
  input rfs_pkg::rfs_req_type req,
  output rfs_pkg::rfs_rsp_type rsp
);
  import rfs_pkg::*;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // one decoder shared by read select and read clear
  function automatic logic [`RFS_NUM_CNT-1:0] dec(input logic [15:0] a);
    logic [`RFS_NUM_CNT-1:0] s;
    s = '0;
    case (a)
      `RFS_ADDR_GOOD: s[`RFS_IX_GOOD] = 1'b1;
      `RFS_ADDR_BCAST: s[`RFS_IX_BCAST] = 1'b1;
      `RFS_ADDR_MCAST: s[`RFS_IX_MCAST] = 1'b1;
      `RFS_ADDR_MIN: s[`RFS_IX_MIN] = 1'b1;
      `RFS_ADDR_BIN2: s[`RFS_IX_BIN2] = 1'b1;
      `RFS_ADDR_BIN3: s[`RFS_IX_BIN3] = 1'b1;
      `RFS_ADDR_BIN4: s[`RFS_IX_BIN4] = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  logic [`RFS_NUM_CNT-1:0] sel;
  logic [`RFS_NUM_CNT-1:0] clr;
  logic [`RFS_NUM_CNT-1:0] inc;
  logic [`RFS_CNT_W-1:0] cnt [`RFS_NUM_CNT];
  logic ok;
  logic [15:0] len;

  assign sel = dec(req.addr);
  // writes never reach the counters, only reads clear them
  assign clr = req.rd ? sel : '0;

  // ----------------------------------------------------------------------
  // frame classification
  // ----------------------------------------------------------------------
  // first transmitted bit of the address is bit 0 of the first octet,
  // held here in bit 40 with the first octet in the top byte
  always_comb begin
    ok = frame_valid && frame.good;
    len = frame.length;
    inc = '0;
    inc[`RFS_IX_GOOD] = ok;
    inc[`RFS_IX_BCAST] = ok && frame.dest_addr == `RFS_BCAST_DA;
    inc[`RFS_IX_MCAST] = ok && frame.dest_addr[`RFS_MCAST_BIT];
    // bins are disjoint ranges, so at most one fires
    inc[`RFS_IX_MIN] = ok && len == `RFS_LEN_MIN;
    inc[`RFS_IX_BIN2] = ok && len >= `RFS_LEN_B2_LO
                        && len <= `RFS_LEN_B2_HI;
    inc[`RFS_IX_BIN3] = ok && len >= `RFS_LEN_B3_LO
                        && len <= `RFS_LEN_B3_HI;
    inc[`RFS_IX_BIN4] = ok && len >= `RFS_LEN_B4_LO
                        && len <= `RFS_LEN_B4_HI;
  end

  // ----------------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `RFS_NUM_CNT; i++) begin : g_cnt
    rfs_sat_counter #(
      .WIDTH(`RFS_CNT_W)
    ) u_cnt (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .inc(inc[i]),
      .clr(clr[i]),
      .count(cnt[i])
    );
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // value is captured in the same edge that clears the counter, so the
  // host sees the count before the clear; unmapped reads return zero
  rfs_rsp_type rsp_q;
  rfs_rsp_type rsp_d;

  always_comb begin
    rsp_d = '0;
    if (req.rd) begin
      rsp_d.hit = |sel;
      for (int k = 0; k < `RFS_NUM_CNT; k++) begin
        if (sel[k]) begin
          rsp_d.rdata = cnt[k];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_good_inc;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && !clr[`RFS_IX_GOOD] && cnt[`RFS_IX_GOOD] != `RFS_CNT_MAX) |=>
      cnt[`RFS_IX_GOOD] == $past(cnt[`RFS_IX_GOOD]) + `RFS_CNT_ONE;
  endproperty
  a_good_inc: assert property (p_good_inc)
    else $error("good frame not counted");

  property p_bcast;
    @(posedge ref_clk) disable iff (sys_rst)
    (!clr[`RFS_IX_BCAST] && !inc[`RFS_IX_BCAST]) |=>
      cnt[`RFS_IX_BCAST] == $past(cnt[`RFS_IX_BCAST]);
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast count moved without a frame");

  property p_mcast;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && frame.dest_addr[`RFS_MCAST_BIT] && !clr[`RFS_IX_MCAST]
      && cnt[`RFS_IX_MCAST] != `RFS_CNT_MAX) |=>
      cnt[`RFS_IX_MCAST] == $past(cnt[`RFS_IX_MCAST]) + `RFS_CNT_ONE;
  endproperty
  a_mcast: assert property (p_mcast)
    else $error("multicast frame not counted");

  property p_min;
    @(posedge ref_clk) disable iff (sys_rst)
    inc[`RFS_IX_MIN] |-> len == `RFS_LEN_MIN;
  endproperty
  a_min: assert property (p_min)
    else $error("minimum bin on wrong length");

  property p_bin2;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && len == `RFS_LEN_B2_HI) |->
      inc[`RFS_IX_BIN2] && !inc[`RFS_IX_BIN3];
  endproperty
  a_bin2: assert property (p_bin2)
    else $error("127 byte frame misbinned");

  property p_bin3;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && len == `RFS_LEN_B3_LO) |->
      inc[`RFS_IX_BIN3] && !inc[`RFS_IX_BIN2];
  endproperty
  a_bin3: assert property (p_bin3)
    else $error("128 byte frame misbinned");

  property p_bin4;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && len == `RFS_LEN_B4_HI) |-> inc[`RFS_IX_BIN4];
  endproperty
  a_bin4: assert property (p_bin4)
    else $error("511 byte frame misbinned");

  property p_one_bin;
    @(posedge ref_clk) disable iff (sys_rst)
    $onehot0(inc[`RFS_IX_BIN4:`RFS_IX_MIN]);
  endproperty
  a_one_bin: assert property (p_one_bin)
    else $error("frame counted in two bins");

  property p_read_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (req.rd && sel[`RFS_IX_GOOD] && !inc[`RFS_IX_GOOD]) |=>
      cnt[`RFS_IX_GOOD] == `RFS_CNT_RESET
      && rsp.rdata == $past(cnt[`RFS_IX_GOOD]);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not return then clear");

  property p_write_none;
    @(posedge ref_clk) disable iff (sys_rst)
    (req.wr && !req.rd && !inc[`RFS_IX_BCAST]) |=>
      cnt[`RFS_IX_BCAST] == $past(cnt[`RFS_IX_BCAST]);
  endproperty
  a_write_none: assert property (p_write_none)
    else $error("write changed a counter");

  // the no-change checks above would pass a detector stuck at zero,
  // so the positive direction is checked as well
  property p_bcast_inc;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && frame.dest_addr == `RFS_BCAST_DA && !clr[`RFS_IX_BCAST]
      && cnt[`RFS_IX_BCAST] != `RFS_CNT_MAX) |=>
      cnt[`RFS_IX_BCAST] == $past(cnt[`RFS_IX_BCAST]) + `RFS_CNT_ONE;
  endproperty
  a_bcast_inc: assert property (p_bcast_inc)
    else $error("broadcast frame not counted");

  property p_min_inc;
    @(posedge ref_clk) disable iff (sys_rst)
    (ok && len == `RFS_LEN_MIN) |-> inc[`RFS_IX_MIN];
  endproperty
  a_min_inc: assert property (p_min_inc)
    else $error("64 byte frame not binned");

  property p_no_bin;
    @(posedge ref_clk) disable iff (sys_rst)
    (len < `RFS_LEN_MIN || len > `RFS_LEN_B4_HI) |->
      inc[`RFS_IX_BIN4:`RFS_IX_MIN] == '0;
  endproperty
  a_no_bin: assert property (p_no_bin)
    else $error("frame outside the bins was binned");

  property p_bad_frame;
    @(posedge ref_clk) disable iff (sys_rst)
    (frame_valid && !frame.good) |-> inc == '0;
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("errored frame was counted");

  property p_write_min;
    @(posedge ref_clk) disable iff (sys_rst)
    (req.wr && !req.rd && !inc[`RFS_IX_MIN]) |=>
      cnt[`RFS_IX_MIN] == $past(cnt[`RFS_IX_MIN]);
  endproperty
  a_write_min: assert property (p_write_min)
    else $error("write changed the minimum bin");
endmodule

// ===== rfs_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------------
module rfs_host_model
  import rfs_pkg::*;
(
  // access wanted by the bench
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] addr,
  // register port of the device
  output rfs_pkg::rfs_req_type req
);
  // write data is junk on purpose, the device must ignore it anyway
  always_comb begin
    req = '{rd, wr, addr, wr ? 32'hFFFF_FFFF : 32'h5A5A_5A5A};
  end
endmodule

// ===== mac_rx_frame_stats_tb.sv
`timescale 1ns/1ps
module mac_rx_frame_stats_tb;
  import rfs_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic frame_valid = 1'b0;
  rfs_frame_type frame = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  rfs_req_type req;
  rfs_rsp_type rsp;
  int errors = 0;
  int checks_done = 0;
  localparam logic [47:0] UNI = 48'h0200_0000_0001;
  logic [15:0] lens [9] = '{16'h003F, 16'h0040, 16'h0041, 16'h007F,
    16'h0080, 16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
  logic [31:0] want [7] = '{32'h0000_000B, 32'h0000_0001, 32'h0000_0002,
    32'h0000_0002, 32'h0000_0003, 32'h0000_0002, 32'h0000_0002};
  // clock at 5 ns
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  rfs_host_model u_rfs_host_model (.rd(rd), .wr(wr), .addr(addr),
    .req(req));
  rfs_rx_stats u_rfs_rx_stats (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .frame_valid(frame_valid), .frame(frame), .req(req), .rsp(rsp));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask
  // one frame per call; valid stays high so frames run back to back
  // without a same-step drop and rise, stop ends a burst
  task automatic frm(input logic good, input logic [47:0] da,
    input logic [15:0] len);
    frame_valid = 1'b1;
    frame = '{good, da, len};
    @(negedge ref_clk);
  endtask
  // read leaves rd high so reads can run back to back; stop ends them
  task automatic rdw(input logic [15:0] a, input logic [31:0] exp,
    input logic hit);
    rd = 1'b1;
    addr = a;
    @(negedge ref_clk);
    chk("hit", {31'h0, rsp.hit}, {31'h0, hit});
    chk("rdata", rsp.rdata, exp);
  endtask
  task automatic stop;
    rd = 1'b0;
    frame_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rdw(16'h0043 + 16'(i), 32'h0000_0000, 1'b1);
    end
    rdw(16'h004A, 32'h0000_0000, 1'b0);
    rdw(16'h0042, 32'h0000_0000, 1'b0);
    stop;
    $display("reset values done");
  endtask
  // every bin edge, a bad frame, broadcast and multicast, back to back
  task automatic t_bins;
    foreach (lens[i]) frm(1'b1, UNI, lens[i]);
    frm(1'b0, UNI, 16'h0040);
    frm(1'b1, 48'hFFFF_FFFF_FFFF, 16'h0040);
    frm(1'b1, 48'h0100_0000_0005, 16'h0064);
    stop;
    for (int i = 0; i < 7; i++) begin
      rdw(16'h0043 + 16'(i), want[i], 1'b1);
    end
    for (int i = 0; i < 7; i++) begin
      rdw(16'h0043 + 16'(i), 32'h0000_0000, 1'b1);
    end
    stop;
    $display("bins done");
  endtask
  task automatic t_write;
    frm(1'b1, UNI, 16'h0040);
    stop;
    wr = 1'b1;
    addr = 16'h0046;
    @(negedge ref_clk);
    wr = 1'b0;
    chk("write answer", {31'h0, rsp.hit}, 32'h0000_0000);
    chk("write data", rsp.rdata, 32'h0000_0000);
    rdw(16'h0046, 32'h0000_0001, 1'b1);
    rdw(16'h0043, 32'h0000_0001, 1'b1);
    stop;
    $display("write ignored done");
  endtask
  // frame lands in the very cycle of the clearing read
  task automatic t_race;
    frm(1'b1, UNI, 16'h00C8);
    rd = 1'b1;
    addr = 16'h0043;
    frm(1'b1, UNI, 16'h00C8);
    frame_valid = 1'b0;
    chk("race hit", {31'h0, rsp.hit}, 32'h0000_0001);
    chk("race read", rsp.rdata, 32'h0000_0001);
    rdw(16'h0043, 32'h0000_0001, 1'b1);
    rdw(16'h0048, 32'h0000_0002, 1'b1);
    stop;
    $display("read race done");
  endtask
  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset;
    t_bins;
    t_write;
    t_race;
    tally_and_finish;
  end
  // tests need about 65 cycles, so 2000 means a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule
